// File: hw/window_pkg.sv
// constants, field layout and carrier types for the indirect register window
// assumes a 32-bit apb slave on one 200 MHz clock with byte-wide targets behind it
package window_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CONTROL_IDX = 8'hb0;
  localparam logic [7:0] OFFSET_IDX  = 8'hb1;
  localparam logic [7:0] VALUE_IDX   = 8'hb2;

  // window_control fields
  localparam int          SEL_MSB       = 5;
  localparam int          SEL_LSB       = 2;
  localparam int          STEP_BIT      = 1;
  localparam int          PREFETCH_BIT  = 0;
  localparam int          CTL_WIDTH     = 6;
  localparam logic [5:0]  CTL_RESET     = 6'h1c;  // select code 0x7, both modes off

  // target select codes
  localparam logic [3:0]  SEL_PATTERN   = 4'h0;
  localparam logic [3:0]  SEL_PORT0     = 4'h1;
  localparam logic [3:0]  SEL_PORT3     = 4'h4;
  localparam logic [3:0]  SEL_BCAST     = 4'h6;
  localparam logic [3:0]  SEL_LAST      = 4'h7;
  localparam logic [7:0]  BCAST_MASK    = 8'h1e;  // receiver ports 0..3
  localparam int          NUM_BLOCKS    = 8;

  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [7:0]  ONE_STEP      = 8'h01;

  // request towards the target blocks; strobes carry one bit per block code, four bits for a broadcast write
  typedef struct packed {
    logic [7:0] wr_stb;
    logic [7:0] rd_stb;
    logic [7:0] offset;
    logic [7:0] wdata;
  } target_req_t;

  typedef enum logic {
    APB_IDLE,
    APB_DONE
  } apb_state_t;

endpackage : window_pkg

// File: hw/indirect_register_access_port.sv
// apb slave that opens an indirect byte window onto eight internal register blocks
// assumes target blocks run on pclk and return read data combinationally for the offset
//
// Function
// - select field steers accesses, resets to 0x7
// - code 0110 writes all four receiver ports
// - auto-increment bumps offset after each value read and each value write with pstrb[0] set
// - prefetch mode strobes read on offset write
// - prefetch plus increment strobes after data reads
// - offset register addresses every indirect access
// - data write forwards byte to target
// - data read returns selected target byte
`timescale 1ns/1ps
`default_nettype none

module indirect_register_access_port #(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  // apb slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [ADDR_WIDTH-1:0]                  paddr,
  input  wire logic [31:0]                            pwdata,
  input  wire logic [3:0]                             pstrb,
  output var  logic [31:0]                            prdata,
  output var  logic                                   pready,
  output var  logic                                   pslverr,
  // target blocks
  output var  window_pkg::target_req_t                target_req,
  input  wire logic [window_pkg::NUM_BLOCKS-1:0][7:0] target_value
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // one strobe bit per block code; unused codes reach nobody
  function automatic logic [7:0] block_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = window_pkg::ZERO_BYTE;
    if (sel == window_pkg::SEL_BCAST) begin
      m = window_pkg::BCAST_MASK;
    end else if (sel <= window_pkg::SEL_LAST) begin
      m[sel[2:0]] = 1'b1;
    end
    return m;
  endfunction : block_mask

  // reads have one source; broadcast code reads back receiver port 0
  function automatic logic [7:0] read_mask(input logic [3:0] sel);
    logic [7:0] m;
    m = block_mask(sel);
    if (sel == window_pkg::SEL_BCAST) begin
      m = block_mask(window_pkg::SEL_PORT0);
    end
    return m;
  endfunction : read_mask

  // aligned word hit on a register index; the byte address is four times the index
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] idx);
    logic word_ok;
    word_ok = (a[1:0] == 2'b00);
    return word_ok && (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx));
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // state

  window_pkg::apb_state_t                  state_q,  state_d;
  logic [window_pkg::CTL_WIDTH-1:0]        ctl_q,    ctl_d;
  logic [7:0]                              off_q,    off_d;
  window_pkg::target_req_t                 req_q,    req_d;
  logic [31:0]                             prdata_q, prdata_d;
  logic                                    pready_q, pready_d;
  logic                                    slverr_q, slverr_d;

  // decoded control fields and address hits, from registered state or the live apb request
  logic [3:0]  sel;
  logic        step_en;
  logic        prefetch_en;
  logic        hit_ctl;
  logic        hit_off;
  logic        hit_val;
  logic        commit;
  logic [7:0]  sel_value;
  logic [7:0]  next_off;

  assign sel         = ctl_q[window_pkg::SEL_MSB:window_pkg::SEL_LSB];
  assign step_en     = ctl_q[window_pkg::STEP_BIT];
  assign prefetch_en = ctl_q[window_pkg::PREFETCH_BIT];
  assign hit_ctl     = hit(paddr, window_pkg::CONTROL_IDX);
  assign hit_off     = hit(paddr, window_pkg::OFFSET_IDX);
  assign hit_val     = hit(paddr, window_pkg::VALUE_IDX);
  // the one edge where the master samples pready; all side effects land here
  assign commit      = psel && penable && pready_q;
  assign next_off    = 8'(off_q + window_pkg::ONE_STEP);  // 8-bit sum wraps 0xff to 0x00

  // read_mask is one-hot or empty, so this loop is a plain mux with zero as the miss value
  always_comb begin
    logic [7:0] rm;
    rm        = read_mask(sel);
    sel_value = window_pkg::ZERO_BYTE;
    for (int i = 0; i < window_pkg::NUM_BLOCKS; i++) begin
      if (rm[i]) begin
        sel_value = target_value[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb sequencing and register effects

  always_comb begin
    state_d  = state_q;
    ctl_d    = ctl_q;
    off_d    = off_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    slverr_d = 1'b0;
    req_d    = req_q;
    // strobes are single-cycle pulses
    req_d.wr_stb = window_pkg::ZERO_BYTE;
    req_d.rd_stb = window_pkg::ZERO_BYTE;
    case (state_q)
      window_pkg::APB_IDLE: begin
        // one wait state precedes the cycle in which read data is sampled
        // read data is captured here, a cycle ahead of pready, from the byte the target shows now
        if (psel && penable) begin
          pready_d = 1'b1;
          slverr_d = !(hit_ctl || hit_off || hit_val);
          prdata_d = '0;
          if (hit_ctl) begin
            prdata_d[window_pkg::CTL_WIDTH-1:0] = ctl_q;  // bits 7:6 stay zero
          end else if (hit_off) begin
            prdata_d[7:0] = off_q;
          end else if (hit_val) begin
            prdata_d[7:0] = sel_value;
          end
          state_d = window_pkg::APB_DONE;
        end
      end
      window_pkg::APB_DONE: begin
        state_d = window_pkg::APB_IDLE;
        // writes land only at the ready edge; a cleared pstrb[0] leaves every register alone
        // an offset write never steps, so software can reload the window at any point
        if (commit && pwrite && pstrb[0]) begin
          if (hit_ctl) begin
            ctl_d = pwdata[window_pkg::CTL_WIDTH-1:0];
          end else if (hit_off) begin
            off_d = pwdata[7:0];
            if (prefetch_en) begin
              req_d.rd_stb = read_mask(sel);
              req_d.offset = pwdata[7:0];
            end
          end else if (hit_val) begin
            req_d.wr_stb = block_mask(sel);
            req_d.offset = off_q;
            req_d.wdata  = pwdata[7:0];
            if (step_en) begin
              off_d = next_off;
            end
          end
        end else if (commit && !pwrite && hit_val && step_en) begin
          // only value reads step; the follow-on strobe already carries the new offset
          off_d = next_off;
          if (prefetch_en) begin
            req_d.rd_stb = read_mask(sel);
            req_d.offset = next_off;
          end
        end
      end
      default: begin
        state_d = window_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // target strobes clear here too, so a reset in mid-access leaves no pulse behind
      state_q  <= window_pkg::APB_IDLE;
      ctl_q    <= window_pkg::CTL_RESET;
      off_q    <= window_pkg::ZERO_BYTE;
      req_q    <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      slverr_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      ctl_q    <= ctl_d;
      off_q    <= off_d;
      req_q    <= req_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = slverr_q;
  assign target_req = req_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // the target request is registered, so strobe checks look one cycle after the ready edge
  // all checks share pclk and are off while reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // decoded commits shared by the checks; rd_start is the edge at which read data is captured
  logic wr_val;
  logic rd_val;
  logic wr_ctl;
  logic wr_off;
  logic rd_start;
  assign wr_val   = commit && pwrite && pstrb[0] && hit_val;
  assign rd_val   = commit && !pwrite && hit_val;
  assign wr_ctl   = commit && pwrite && pstrb[0] && hit_ctl;
  assign wr_off   = commit && pwrite && pstrb[0] && hit_off;
  assign rd_start = state_q == window_pkg::APB_IDLE && psel && penable && hit_val && !pwrite;

  chk_select_write: assert property (wr_ctl |=>
    sel == $past(pwdata[window_pkg::SEL_MSB:window_pkg::SEL_LSB]))
    else $error("select field did not take the written code");

  chk_bcast_write: assert property (wr_val && sel == window_pkg::SEL_BCAST |=>
    target_req.wr_stb == window_pkg::BCAST_MASK ##1 target_req.wr_stb == window_pkg::ZERO_BYTE)
    else $error("broadcast write did not reach exactly the four ports");

  chk_offset_step: assert property ((wr_val || rd_val) && step_en |=>
    off_q == 8'($past(off_q) + window_pkg::ONE_STEP))
    else $error("offset did not advance by one");

  chk_offset_wrap: assert property ((wr_val || rd_val) && step_en && off_q == 8'hff |=>
    off_q == window_pkg::ZERO_BYTE && $stable(sel))
    else $error("offset did not wrap inside the block");

  chk_prefetch_addr: assert property (commit && pwrite && pstrb[0] && hit_off && prefetch_en
    && sel <= window_pkg::SEL_LAST |=> target_req.rd_stb != window_pkg::ZERO_BYTE
    && target_req.offset == $past(pwdata[7:0]))
    else $error("offset write in prefetch mode gave no read strobe");

  chk_prefetch_follow: assert property (rd_val && step_en && prefetch_en && sel <= window_pkg::SEL_LAST
    |=> target_req.rd_stb != window_pkg::ZERO_BYTE && target_req.offset == off_q)
    else $error("no follow-on read strobe at the next offset");

  chk_offset_hold: assert property (!commit |=> $stable(off_q))
    else $error("offset moved without an access");

  chk_value_write: assert property (wr_val |=> target_req.wdata == $past(pwdata[7:0])
    && target_req.offset == $past(off_q) && target_req.wr_stb == block_mask($past(sel)))
    else $error("indirect write carried wrong byte or offset");

  chk_value_read: assert property (state_q == window_pkg::APB_IDLE && psel && penable
    && hit_val && !pwrite |=> prdata[7:0] == $past(sel_value) && pready)
    else $error("read did not return the selected target byte");

  chk_ctl_upper: assert property (pready && hit_ctl && !pwrite |-> prdata[31:6] == '0)
    else $error("control read showed nonzero upper bits");

  // decode, offset load, strobe and ready shape, read data, and refused accesses
  chk_select_dead: assert property (wr_val && sel > window_pkg::SEL_LAST |=>
    target_req.wr_stb == window_pkg::ZERO_BYTE)
    else $error("write under an unused select code reached a block");

  chk_offset_load: assert property (wr_off |=> off_q == $past(pwdata[7:0]))
    else $error("offset register did not take the written byte");

  chk_write_source: assert property (target_req.wr_stb != window_pkg::ZERO_BYTE |-> $past(wr_val))
    else $error("write strobe without a committed value write");

  chk_strobe_pulse: assert property (target_req.rd_stb != window_pkg::ZERO_BYTE |=>
    target_req.rd_stb == window_pkg::ZERO_BYTE)
    else $error("read strobe stood longer than one cycle");

  chk_bcast_read: assert property (rd_start && sel == window_pkg::SEL_BCAST |=>
    prdata[7:0] == $past(target_value[window_pkg::SEL_PORT0]))
    else $error("broadcast read did not come from receiver port 0");

  chk_read_upper: assert property (pready && hit_val && !pwrite |-> prdata[31:8] == '0)
    else $error("value read showed nonzero upper bits");

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");

  chk_unmapped_quiet: assert property (commit && pslverr |=> $stable(ctl_q) && $stable(off_q)
    && target_req.wr_stb == window_pkg::ZERO_BYTE)
    else $error("refused access changed the window");

  cov_bcast_write:   cover property (wr_val && sel == window_pkg::SEL_BCAST);
  cov_stream_read:   cover property (rd_val && step_en && prefetch_en ##[1:20] rd_val);
  cov_offset_wrap:   cover property (wr_val && step_en && off_q == 8'hff);
  cov_unmapped:      cover property (pready && pslverr);
  cov_prefetch_addr: cover property (wr_off && prefetch_en);

endmodule : indirect_register_access_port

`default_nettype wire

// File: bench/target_blocks.sv
// behavioural model of the eight register blocks behind the indirect window
// assumes one-cycle strobes on pclk; view_off is the window offset the bench tracks
`timescale 1ns/1ps
`default_nettype none
module target_blocks (
  // clock
  input  wire logic                    pclk,
  // requests from the window
  input  wire window_pkg::target_req_t req,
  input  wire logic [7:0]              view_off,
  // answers and prefetch log
  output var  logic [7:0][7:0]         value,
  output var  int                      rd_count,
  output var  logic [7:0]              rd_off,
  output var  logic [7:0]              rd_mask
);
  logic [7:0] mem [8][256];
  initial begin
    rd_count = 0;
    rd_off = 8'h00;
    rd_mask = 8'h00;
    // contents differ per part, so start from a fixed i xor 0x5a pattern that the bench checks untouched bytes against
    for (int b = 0; b < 8; b++) for (int i = 0; i < 256; i++) mem[b][i] = 8'(i) ^ 8'h5a;
  end
  always @(posedge pclk) begin
    for (int b = 0; b < 8; b++) if (req.wr_stb[b]) mem[b][req.offset] <= req.wdata;
    if (|req.rd_stb) begin
      rd_count <= rd_count + 1;
      rd_off <= req.offset;
      rd_mask <= req.rd_stb;
    end
  end
  always_comb for (int b = 0; b < 8; b++) value[b] = mem[b][view_off];
endmodule : target_blocks
`default_nettype wire

// File: bench/test_indirect_register_access_port.sv
// self-checking bench for the indirect register window
// assumes the apb slave answers with a registered pready; target blocks are modelled
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module test_indirect_register_access_port;
  localparam logic [11:0] CTL = 12'h02c0, OFS = 12'h02c4, VAL = 12'h02c8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, step_on = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] view_off = 8'h00, rd_off, rd_mask;
  logic [7:0][7:0] tval;
  window_pkg::target_req_t req;
  int rd_count, bad_count = 0, num_checks = 0;
  always #2.5 pclk = ~pclk;
  indirect_register_access_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .target_req(req), .target_value(tval));
  target_blocks model (.pclk(pclk), .req(req), .view_off(view_off), .value(tval), .rd_count(rd_count),
    .rd_off(rd_off), .rd_mask(rd_mask));
  //////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the ready edge; only the watchdog ends a hung wait
    do begin @(posedge pclk); end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // the model must follow the window offset, which the target request only shows late
    if (wr && a == CTL) step_on = d[1];
    if (wr && a == OFS && pstrb[0]) view_off <= d;
    else if (a == VAL && step_on && !e && (!wr || pstrb[0])) view_off <= view_off + 8'h01;
  endtask : apb
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask : settle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_ctl();
    apb(0, CTL, 8'h00); `CHK(r, 32'h0000_001c)
    apb(0, OFS, 8'h00); `CHK(r, 32'h0000_0000)
    `CHK(e, 1'b0)
    apb(1, CTL, 8'hff); apb(0, CTL, 8'h00); `CHK(r, 32'h0000_003f)
  endtask : t_reset_and_ctl
  task automatic t_route();
    logic [7:0] o;
    for (int i = 0; i < 8; i++) if (i != 6) begin
      o = 8'(8'h40 + i);
      apb(1, CTL, 8'(i * 4)); apb(1, OFS, o); apb(1, VAL, o ^ 8'hff);
      apb(0, VAL, 8'h00); `CHK(r, {24'h00_0000, o ^ 8'hff})
      settle(); `CHK(model.mem[i][o], o ^ 8'hff)
      `CHK(model.mem[i ^ 1][o], o ^ 8'h5a)
    end
    `CHK(rd_count, 0)
  endtask : t_route
  task automatic t_bcast();
    apb(1, CTL, 8'h18); apb(1, OFS, 8'h10); apb(1, VAL, 8'h3c); settle();
    for (int b = 0; b < 8; b++) `CHK(model.mem[b][8'h10], (b >= 1 && b <= 4) ? 8'h3c : 8'h4a)
    apb(1, CTL, 8'h04); apb(1, VAL, 8'h77); apb(1, CTL, 8'h18);
    apb(0, VAL, 8'h00); `CHK(r, 32'h0000_0077)
  endtask : t_bcast
  task automatic t_step();
    apb(1, CTL, 8'h0a); apb(1, OFS, 8'hfe);
    apb(1, VAL, 8'h11); apb(1, VAL, 8'h22); apb(1, VAL, 8'h33);
    apb(0, OFS, 8'h00); `CHK(r, 32'h0000_0001)
    settle(); `CHK({model.mem[2][8'hfe], model.mem[2][8'hff], model.mem[2][8'h00]}, 24'h11_2233)
    `CHK(model.mem[3][8'h00], 8'h5a)
    apb(1, OFS, 8'hff); apb(0, VAL, 8'h00); `CHK(r, 32'h0000_0022)
    apb(0, VAL, 8'h00); `CHK(r, 32'h0000_0033)
  endtask : t_step
  task automatic t_prefetch();
    int c;
    c = rd_count;
    apb(1, CTL, 8'h0d); apb(1, OFS, 8'h20); settle();
    `CHK({rd_count == c + 1, rd_off, rd_mask}, {1'b1, 8'h20, 8'h08})
    apb(1, CTL, 8'h0f); apb(1, OFS, 8'h30); apb(0, VAL, 8'h00); settle();
    `CHK({rd_count == c + 3, rd_off}, {1'b1, 8'h31})
    apb(0, OFS, 8'h00); `CHK(r, 32'h0000_0031)
    apb(0, VAL, 8'h00); `CHK(r, 32'h0000_006b)
    settle(); `CHK({rd_count == c + 4, rd_off}, {1'b1, 8'h32})
    apb(1, 12'h02cc, 8'h55); `CHK(e, 1'b1)
  endtask : t_prefetch
  task automatic t_refuse_and_reset();
    apb(1, CTL, 8'h04); apb(1, OFS, 8'h50);
    pstrb <= 4'he; apb(1, VAL, 8'h99); pstrb <= 4'hf; settle();
    `CHK(model.mem[1][8'h50], 8'h0a)
    apb(1, CTL, 8'h3c); apb(1, VAL, 8'h99); apb(0, VAL, 8'h00); `CHK(r, 32'h0000_0000)
    settle(); `CHK(model.mem[7][8'h50], 8'h0a)
    // reset in mid-run must bring back the control code and a zero offset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    view_off <= 8'h00;
    step_on = 1'b0;
    apb(0, CTL, 8'h00); `CHK(r, 32'h0000_001c)
    apb(0, OFS, 8'h00); `CHK(r, 32'h0000_0000)
  endtask : t_refuse_and_reset
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_ctl();
    t_route();
    t_bcast();
    t_step();
    t_prefetch();
    t_refuse_and_reset();
    give_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule : test_indirect_register_access_port
`default_nettype wire
